// >>> core/ccr_regs.sv
// codec control register bank with serial control word receiver and dac data path
`timescale 1ns/10ps
`default_nettype none
// Contract
// - decode five registers at addresses 1..5
// - gain bit7 selects stored or applied gain
// - gain 7-bit half-dB code, reset 0x46
// - filter bit7 selects weak io buffers
// - bits 6:5 select highpass mode, 11 unused
// - bits 4:2 left shift, 11x acts 101
// - bits 1:0 dac off/16/20/loopback mode
// - power-down bit7 selects adaptive quantizer
// - bridge enable, drive, mic and frontend powerdown
// - bit4 hysteresis timeout 50 or 25 ms
// - bits 3:2 compressor gain tracking mode
// - fast rate attack/release codes, reset 0xf7
// - slow rate codes, dual mode only, 0x42
// - unused bits always read zero
// - 12-bit word rw,addr,data msb first
// - five-bit shift saturates to 15 bits
// - register access spans two frame cycles; the code replies one cycle after the word completes, inside the same frame
module ccr_regs
  import ccr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_frame,
  input wire logic i_sdin,
  input wire logic [6:0] i_applied_gain,
  input wire logic [15:0] i_adc_word,
  input wire logic [19:0] i_dac_word,
  input wire logic i_sample_stb,
  output logic [7:0] o_read_data,
  output logic o_read_valid,
  output logic [6:0] o_gain_setting,
  output logic o_weak_io_buffer_enable,
  output logic [1:0] o_highpass_select,
  output logic [2:0] o_shift_amount,
  output logic [1:0] o_dac_mode,
  output logic o_dac_powerdown,
  output logic o_adaptive_quant,
  output logic o_bridge_output_enable,
  output logic o_bridge_drive_strength,
  output logic o_hysteresis_timeout_select,
  output logic [1:0] o_gain_tracking_mode,
  output logic o_mic_supply_powerdown,
  output logic o_input_chain_powerdown,
  output logic [3:0] o_fast_attack,
  output logic [3:0] o_fast_release,
  output logic [3:0] o_slow_attack,
  output logic [3:0] o_slow_release,
  output logic o_slow_rates_active,
  output logic [19:0] o_dac_data
);

  typedef struct packed {
    logic [1:0] frame_sync;
    logic [1:0] sdin_sync;
    logic frame_prev;
    ccr_state_t state;
    logic [3:0] bit_cnt;
    logic [11:0] word;
    logic [7:0] front_gain;
    logic [7:0] filter_shift_dac_control;
    logic [7:0] power_down_control;
    logic [7:0] fast_rate_control;
    logic [7:0] slow_rate_control;
    logic [7:0] read_data;
    logic read_valid;
    logic [19:0] dac_data;
    logic dac_powerdown;
    logic slow_rates_active;
  } ccr_regs_t;

  ccr_regs_t r;
  ccr_regs_t next_r;

  logic frame_rise;
  logic [2:0] shift_eff;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic signed [19:0] shifted;
  logic signed [20:0] wide;

  // synchronised pins only; first stage is read by the second only
  assign frame_rise = r.frame_sync[1] & ~r.frame_prev;
  assign addr = r.word[CCR_WORD_ADDR_LSB +: 3];
  assign wdata = r.word[7:0];

  // codes 11x behave as the five-bit shift
  always_comb begin
    shift_eff = r.filter_shift_dac_control[CCR_SHIFT_LSB +: 3];
    if (shift_eff > CCR_SHIFT_MAX) begin
      shift_eff = CCR_SHIFT_MAX;
    end
  end

  // adc word shifted one bit wider than the dac, so the clamp sees true overflow
  always_comb begin
    wide = signed'({{5{i_adc_word[15]}}, i_adc_word}) <<< shift_eff;
    shifted = 20'(wide);
    if (shift_eff == CCR_SHIFT_MAX) begin
      // sign bit plus 14 magnitude bits kept, overflow clamped
      if (wide > CCR_SAT_POS) begin
        shifted = CCR_SAT_POS;
      end else if (wide < CCR_SAT_NEG) begin
        shifted = CCR_SAT_NEG;
      end
    end
  end

  // next state of the whole bank
  always_comb begin
    next_r = r;
    next_r.frame_sync = {r.frame_sync[0], i_frame};
    next_r.sdin_sync = {r.sdin_sync[0], i_sdin};
    next_r.frame_prev = r.frame_sync[1];
    next_r.read_valid = 1'b0;
    // word capture: frame marks the start, bits arrive msb first
    case (r.state)
      CCR_ST_IDLE: begin
        if (frame_rise) begin
          next_r.state = CCR_ST_SHIFT;
          next_r.bit_cnt = 4'h0;
        end
      end
      CCR_ST_SHIFT: begin
        next_r.word = {r.word[10:0], r.sdin_sync[1]};
        next_r.bit_cnt = r.bit_cnt + 4'h1;
        if (r.bit_cnt == CCR_WORD_LAST) begin
          next_r.state = CCR_ST_IDLE;
        end
      end
      default: begin
        next_r.state = CCR_ST_IDLE;
      end
    endcase
    // word completes one cycle after the last bit; act on it then
    // counter ends one past the last bit index once the whole word is in
    if (r.state == CCR_ST_IDLE && r.bit_cnt == 4'(CCR_WORD_BITS)
        && r.frame_prev == r.frame_sync[1]
        && r.word != 12'h000 && addr != 3'h0) begin
      // the reply comes one cycle after the word completes, inside the same frame
      next_r.bit_cnt = 4'h0;
      if (r.word[CCR_WORD_RW_BIT]) begin
        // reserved addresses are never written by the controller
        if (addr == CCR_ADDR_GAIN) begin
          next_r.front_gain = wdata;
        end else if (addr == CCR_ADDR_FILT) begin
          next_r.filter_shift_dac_control = wdata;
        end else if (addr == CCR_ADDR_PDC) begin
          next_r.power_down_control = wdata;
        end else if (addr == CCR_ADDR_FAST) begin
          next_r.fast_rate_control = wdata;
        end else if (addr == CCR_ADDR_SLOW) begin
          next_r.slow_rate_control = wdata;
        end
      end else begin
        next_r.read_valid = 1'b1;
        if (addr == CCR_ADDR_GAIN) begin
          if (r.front_gain[CCR_GAIN_RDSEL_BIT]) begin
            next_r.read_data = {1'b1, i_applied_gain};
          end else begin
            next_r.read_data = r.front_gain;
          end
        end else if (addr == CCR_ADDR_FILT) begin
          next_r.read_data = r.filter_shift_dac_control;
        end else if (addr == CCR_ADDR_PDC) begin
          next_r.read_data = r.power_down_control;
        end else if (addr == CCR_ADDR_FAST) begin
          next_r.read_data = r.fast_rate_control;
        end else if (addr == CCR_ADDR_SLOW) begin
          next_r.read_data = r.slow_rate_control;
        end else begin
          next_r.read_data = 8'h00;
        end
      end
    end else if (r.state == CCR_ST_IDLE && r.bit_cnt == 4'(CCR_WORD_BITS)
                 && r.frame_prev == r.frame_sync[1]) begin
      next_r.bit_cnt = 4'h0; // zero address disables the control function
    end
    // decodes registered so they leave the block straight from flops
    next_r.dac_powerdown = next_r.filter_shift_dac_control[1:0] == CCR_DAC_OFF;
    next_r.slow_rates_active = next_r.power_down_control[3:2] == CCR_MODE_DUAL;
    // dac input path, updated once per sample
    if (i_sample_stb) begin
      case (r.filter_shift_dac_control[CCR_DAC_LSB +: 2])
        CCR_DAC_OFF: next_r.dac_data = 20'h00000;
        CCR_DAC_SHIFT16: next_r.dac_data = shifted;
        CCR_DAC_DIRECT20: next_r.dac_data = i_dac_word;
        default: next_r.dac_data = shifted; // loopback uses the shifted adc word
      endcase
    end
  end

  // register stage; clock enable freezes everything
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;
      r.state <= CCR_ST_IDLE;
      r.front_gain <= CCR_RST_GAIN;
      r.filter_shift_dac_control <= CCR_RST_FILT;
      r.power_down_control <= CCR_RST_PDC;
      r.fast_rate_control <= CCR_RST_FAST;
      r.slow_rate_control <= CCR_RST_SLOW;
      r.slow_rates_active <= 1'b1; // reset gain mode is dual rate
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  // field outputs straight from the register flops
  assign o_read_data = r.read_data;
  assign o_read_valid = r.read_valid;
  assign o_gain_setting = r.front_gain[6:0];
  assign o_weak_io_buffer_enable = r.filter_shift_dac_control[CCR_WEAK_BIT];
  assign o_highpass_select = r.filter_shift_dac_control[CCR_HPF_LSB +: 2];
  assign o_shift_amount = r.filter_shift_dac_control[CCR_SHIFT_LSB +: 3];
  assign o_dac_mode = r.filter_shift_dac_control[CCR_DAC_LSB +: 2];
  assign o_dac_powerdown = r.dac_powerdown;
  assign o_adaptive_quant = r.power_down_control[CCR_ADAPTQ_BIT];
  assign o_bridge_output_enable = r.power_down_control[CCR_BRIDGE_EN_BIT];
  assign o_bridge_drive_strength = r.power_down_control[CCR_BRIDGE_DRV_BIT];
  assign o_hysteresis_timeout_select = r.power_down_control[CCR_HYST_BIT];
  assign o_gain_tracking_mode = r.power_down_control[CCR_MODE_LSB +: 2];
  assign o_mic_supply_powerdown = r.power_down_control[CCR_MIC_PD_BIT];
  assign o_input_chain_powerdown = r.power_down_control[CCR_FRONT_PD_BIT];
  assign o_fast_attack = r.fast_rate_control[7:4];
  assign o_fast_release = r.fast_rate_control[3:0];
  assign o_slow_attack = r.slow_rate_control[7:4];
  assign o_slow_release = r.slow_rate_control[3:0];
  assign o_slow_rates_active = r.slow_rates_active;
  assign o_dac_data = r.dac_data;

endmodule : ccr_regs
`default_nettype wire

// >>> core/ccr_pkg.sv
// package: register map, field layout, reset values and mode codes of the codec control bank
package ccr_pkg;
  localparam logic [2:0] CCR_ADDR_GAIN = 3'h1;
  localparam logic [2:0] CCR_ADDR_FILT = 3'h2;
  localparam logic [2:0] CCR_ADDR_PDC = 3'h3;
  localparam logic [2:0] CCR_ADDR_FAST = 3'h4;
  localparam logic [2:0] CCR_ADDR_SLOW = 3'h5;
  localparam logic [7:0] CCR_RST_GAIN = 8'h46;
  localparam logic [7:0] CCR_RST_FILT = 8'h11;
  localparam logic [7:0] CCR_RST_PDC = 8'h00;
  localparam logic [7:0] CCR_RST_FAST = 8'hf7;
  localparam logic [7:0] CCR_RST_SLOW = 8'h42;
  // gain register fields
  localparam int CCR_GAIN_RDSEL_BIT = 7;
  localparam logic [6:0] CCR_GAIN_MAX = 7'h52;
  // filter/shift register fields
  localparam int CCR_WEAK_BIT = 7;
  localparam int CCR_HPF_LSB = 5;
  localparam int CCR_SHIFT_LSB = 2;
  localparam int CCR_DAC_LSB = 0;
  localparam logic [1:0] CCR_HPF_UNUSED = 2'h3;
  localparam logic [2:0] CCR_SHIFT_MAX = 3'h5;
  localparam logic [1:0] CCR_DAC_OFF = 2'h0;
  localparam logic [1:0] CCR_DAC_SHIFT16 = 2'h1;
  localparam logic [1:0] CCR_DAC_DIRECT20 = 2'h2;
  localparam logic [1:0] CCR_DAC_LOOPBACK = 2'h3;
  // power-down register fields
  localparam int CCR_ADAPTQ_BIT = 7;
  localparam int CCR_BRIDGE_EN_BIT = 6;
  localparam int CCR_BRIDGE_DRV_BIT = 5;
  localparam int CCR_HYST_BIT = 4;
  localparam int CCR_MODE_LSB = 2;
  localparam int CCR_MIC_PD_BIT = 1;
  localparam int CCR_FRONT_PD_BIT = 0;
  localparam logic [1:0] CCR_MODE_DUAL = 2'h0;
  // control word layout: rw, 3 address bits, 8 data bits, msb first
  localparam int CCR_WORD_BITS = 12;
  localparam int CCR_WORD_RW_BIT = 11;
  localparam int CCR_WORD_ADDR_LSB = 8;
  localparam logic [3:0] CCR_WORD_LAST = 4'hb;
  // 15-bit saturation limits of the shifted word
  localparam logic signed [19:0] CCR_SAT_POS = 20'h03fff;
  localparam logic signed [19:0] CCR_SAT_NEG = 20'hfc000;
  typedef enum logic [1:0] {
    CCR_ST_IDLE = 2'b01,
    CCR_ST_SHIFT = 2'b10
  } ccr_state_t;
endpackage : ccr_pkg

// >>> tb/ccr_props_properties.sv
// checker: timing and decode properties of the control bank
`timescale 1ns/10ps
`default_nettype none
module ccr_props
  import ccr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_frame,
  input wire logic i_sdin,
  input wire logic [6:0] i_applied_gain,
  input wire logic [19:0] i_dac_word,
  input wire logic i_sample_stb,
  input wire logic [7:0] o_read_data,
  input wire logic o_read_valid,
  input wire logic [6:0] o_gain_setting,
  input wire logic [2:0] o_shift_amount,
  input wire logic [1:0] o_dac_mode,
  input wire logic o_dac_powerdown,
  input wire logic [1:0] o_gain_tracking_mode,
  input wire logic o_slow_rates_active,
  input wire logic [19:0] o_dac_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [4:0] cnt;
  // cycles since the frame pin rose, saturating so idle time never wraps
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) cnt <= 5'h1f;
    else if ($rose(i_frame)) cnt <= 5'h00;
    else if (cnt != 5'h1f) cnt <= cnt + 5'h01;
  end
  logic [2:0] rd_addr;
  // address bits of the word in flight, so only gain reads are held to the applied gain
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) rd_addr <= 3'h0;
    else if (cnt >= 5'h01 && cnt <= 5'h03) rd_addr <= {rd_addr[1:0], i_sdin};
  end
  sequence s_direct;
    i_sample_stb && o_dac_mode == CCR_DAC_DIRECT20;
  endsequence
  sequence s_shift5;
    i_sample_stb && o_dac_mode == CCR_DAC_SHIFT16 && o_shift_amount >= CCR_SHIFT_MAX;
  endsequence
  chk_valid_one_cycle: assert property (o_read_valid |=> !o_read_valid)
    else $error("read valid longer than one cycle");
  chk_read_data_holds: assert property ($changed(o_read_data) |-> o_read_valid)
    else $error("read data changed without a reply");
  chk_dac_off_decode: assert property (o_dac_powerdown == (o_dac_mode == CCR_DAC_OFF))
    else $error("dac powerdown decode wrong");
  chk_slow_mode_decode: assert property (o_slow_rates_active == (o_gain_tracking_mode == CCR_MODE_DUAL))
    else $error("slow rate enable decode wrong");
  chk_direct_path: assert property (s_direct |=> o_dac_data == $past(i_dac_word))
    else $error("direct dac word not passed");
  chk_shift_saturate: assert property (s_shift5 |=> ($signed(o_dac_data) <= CCR_SAT_POS
    && $signed(o_dac_data) >= CCR_SAT_NEG))
    else $error("five-bit shift not saturated");
  chk_applied_gain_read: assert property (o_read_valid && o_read_data[7] && rd_addr == CCR_ADDR_GAIN
    |-> o_read_data[6:0] == $past(i_applied_gain))
    else $error("applied gain readback wrong");
  chk_word_complete: assert property (($changed(o_gain_setting) || o_read_valid)
    |-> (cnt >= 5'h0f && cnt <= 5'h13))
    else $error("register acted outside word completion");
endmodule : ccr_props
bind ccr_regs ccr_props ccr_props_inst (.*);
`default_nettype wire

// >>> tb/ccr_host_model.sv
// partner model: controller side that shifts control words into the bank
`timescale 1ns/10ps
`default_nettype none
module ccr_host_model (
  input wire logic i_clk,
  output logic o_frame,
  output logic o_sdin
);
  initial begin
    o_frame = 1'b0;
    o_sdin = 1'b0;
  end
  // one word per frame rise: rw, address, data, msb first
  task automatic send(input logic [11:0] w);
    @(negedge i_clk);
    o_frame = 1'b1;
    @(negedge i_clk);
    for (int i = 11; i >= 0; i--) begin
      o_sdin = w[i];
      @(negedge i_clk);
    end
    // frame held past the last bit, else its fall delays the act by a cycle
    repeat (3) @(negedge i_clk);
    o_frame = 1'b0;
    o_sdin = ~o_sdin;
    // idle gap stands in for the reply frame of the access
    repeat (12) @(negedge i_clk);
  endtask : send
endmodule : ccr_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// testbench: register writes, readback, reset values and dac path
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ccr_pkg::*;
  logic i_clk = 0, i_arst_n = 0, i_ce = 1, i_sample_stb = 0, seen = 0;
  logic [6:0] i_applied_gain = 7'h2a;
  logic [15:0] i_adc_word = 16'h0000;
  logic [19:0] i_dac_word = 20'h00000, o_dac_data;
  wire logic i_frame, i_sdin;
  logic [7:0] o_read_data, rd, o_fast_attack_unused;
  logic o_read_valid, o_weak_io_buffer_enable, o_dac_powerdown, o_adaptive_quant;
  logic o_bridge_output_enable, o_bridge_drive_strength, o_hysteresis_timeout_select;
  logic o_mic_supply_powerdown, o_input_chain_powerdown, o_slow_rates_active;
  logic [6:0] o_gain_setting;
  logic [1:0] o_highpass_select, o_dac_mode, o_gain_tracking_mode;
  logic [2:0] o_shift_amount;
  logic [3:0] o_fast_attack, o_fast_release, o_slow_attack, o_slow_release;
  int errors = 0, total_checks = 0;
  logic [7:0] rv [1:5] = '{CCR_RST_GAIN, CCR_RST_FILT, CCR_RST_PDC, CCR_RST_FAST, CCR_RST_SLOW};
  // rows: address, write data, expected readback and fields
  logic [18:0] rows [6] = '{{3'h1, 8'h52, 8'h52}, {3'h2, 8'hb8, 8'hb8}, {3'h3, 8'h7d, 8'h7d},
    {3'h4, 8'h0f, 8'h0f}, {3'h5, 8'ha5, 8'ha5}, {3'h6, 8'h55, 8'h00}};
  ccr_regs ccr_regs_inst (.*);
  ccr_host_model ccr_host_model_inst (.i_clk(i_clk), .o_frame(i_frame), .o_sdin(i_sdin));
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  // catch the one-cycle reply while the host is still busy
  always @(posedge i_clk) begin
    if (o_read_valid === 1'b1) begin
      seen <= 1'b1;
      rd <= o_read_data;
    end
  end
  function automatic logic [7:0] flds(input logic [2:0] a);
    case (a)
      3'h1: flds = {1'b0, o_gain_setting};
      3'h2: flds = {o_weak_io_buffer_enable, o_highpass_select, o_shift_amount, o_dac_mode};
      3'h3: flds = {o_adaptive_quant, o_bridge_output_enable, o_bridge_drive_strength,
        o_hysteresis_timeout_select, o_gain_tracking_mode, o_mic_supply_powerdown,
        o_input_chain_powerdown};
      3'h4: flds = {o_fast_attack, o_fast_release};
      3'h5: flds = {o_slow_attack, o_slow_release};
      default: flds = 8'h00;
    endcase
  endfunction : flds
  task automatic check(input string nm, input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
    seen = 1'b0;
    ccr_host_model_inst.send({wr, a, d});
  endtask : xfer
  task automatic sample(input logic [19:0] exp);
    @(negedge i_clk);
    i_sample_stb = 1'b1;
    @(negedge i_clk);
    i_sample_stb = 1'b0;
    check("dac_data", o_dac_data, exp);
  endtask : sample
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // watchdog: the sequence needs about 740 cycles
  initial begin
    repeat (6000) @(posedge i_clk);
    errors++;
    finish_test();
  end
  initial begin
    repeat (3) @(negedge i_clk);
    i_arst_n = 1'b1;
    foreach (rows[k]) begin
      if (rows[k][18:16] < 3'h6) xfer(1'b1, rows[k][18:16], rows[k][15:8]);
      check("fields", flds(rows[k][18:16]), rows[k][7:0]);
      xfer(1'b0, rows[k][18:16], 8'h00);
      check("read_valid", seen, 1'b1);
      check("read_data", rd, rows[k][7:0]);
      $display("row %0d done", k);
    end
    xfer(1'b1, 3'h1, 8'hc6);
    check("gain", o_gain_setting, 7'h46);
    xfer(1'b0, 3'h1, 8'h00);
    check("gain_read", rd, {1'b1, i_applied_gain});
    xfer(1'b1, 3'h0, 8'hff);
    xfer(1'b0, 3'h0, 8'h00);
    check("addr0_quiet", {seen, o_gain_setting}, {1'b0, 7'h46});
    $display("gain and address zero done");
    xfer(1'b1, 3'h2, 8'h12);
    i_dac_word = 20'h12345;
    sample(20'h12345);
    xfer(1'b1, 3'h2, 8'h15);
    i_adc_word = 16'h7fff;
    sample(20'h03fff);
    i_adc_word = 16'h8000;
    sample(20'hfc000);
    xfer(1'b1, 3'h2, 8'h19);
    i_adc_word = 16'h0100;
    sample(20'h02000);
    xfer(1'b1, 3'h2, 8'h13);
    sample(20'h01000); // loopback through the shifter
    xfer(1'b1, 3'h2, 8'h10);
    sample(20'h00000);
    check("dac_pd", o_dac_powerdown, 1'b1);
    $display("dac path done");
    i_arst_n = 1'b0;
    @(negedge i_clk);
    i_arst_n = 1'b1;
    check("dac_pd_rst", o_dac_powerdown, 1'b0);
    check("slow_act_rst", o_slow_rates_active, 1'b1);
    for (int a = 1; a <= 5; a++) begin
      check("reset_fields", flds(3'(a)), rv[a]);
      xfer(1'b0, 3'(a), 8'h00);
      check("reset_read", rd, rv[a]);
    end
    $display("reset values done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
